// File: core/edo_ctrl_regs.svh
`ifndef EDO_CTRL_REGS_SVH
`define EDO_CTRL_REGS_SVH
// ----------------------------------------
// timing figures in ns and derived counts
// ----------------------------------------
`define CLK_PERIOD_NS       20
`define ROW_ACCESS_NS       60
`define COL_ACCESS_NS       15
`define ADDR_ACCESS_NS      30
`define PAGE_CYCLE_NS       40
`define RANDOM_CYCLE_NS     110
`define REFRESH_PERIOD_NS   16000000
`define REFRESH_ROWS        1024
// least times round up, longest times round down
`define ROW_ACCESS_CYC      ((`ROW_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PAGE_CYCLE_CYC      ((`PAGE_CYCLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RANDOM_CYCLE_CYC    ((`RANDOM_CYCLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REFRESH_GAP_CYC     (`REFRESH_PERIOD_NS / `REFRESH_ROWS / `CLK_PERIOD_NS)
`endif

// File: core/edo_ctrl_pkg.sv
package edo_ctrl_pkg;
  // ----------------------------------------
  // controller sequencer states
  // ----------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,  // strobes high, bus released
    ST_ROW   = 6'h02,  // row strobe low, row address then column address on bus
    ST_COL   = 6'h04,  // column strobes low, access running
    ST_HOLD  = 6'h08,  // column strobes high, page still open
    ST_PRE   = 6'h10,  // column strobes high, row strobe raised, precharge wait follows in idle
    ST_REF   = 6'h20   // column-first refresh in progress
  } state_t;
endpackage : edo_ctrl_pkg

// File: core/edo_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "edo_ctrl_regs.svh"

module edo_ctrl #(
  parameter int REFRESH_GAP = `REFRESH_GAP_CYC  // cycles between refreshes
) (
  input  wire logic        clk_sys,                // 50 MHz system clock
  input  wire logic        nrst,                   // synchronous reset, active low
  input  wire logic        req_valid,              // access request, level
  input  wire logic        req_write,              // 1 write, 0 read
  input  wire logic [19:0] req_addr,               // word address, row high
  input  wire logic [1:0]  req_lanes,              // byte lane enables, bit0 lower
  input  wire logic [15:0] req_wdata,              // write data
  input  wire logic        req_keep_page,          // keep row open after access
  output logic             req_ready_q,            // one-cycle accept pulse
  output logic             rsp_valid_q,            // one-cycle read data pulse
  output logic [15:0]      rsp_rdata_q,            // read data
  output logic             row_strobe_n_q,         // row strobe to memory
  output logic             low_byte_col_strobe_n_q,  // lower column strobe
  output logic             high_byte_col_strobe_n_q, // upper column strobe
  output logic             write_en_n_q,           // write enable to memory
  output logic             out_en_n_q,             // output enable to memory
  output logic [9:0]       mux_address_bus_q,      // multiplexed address
  output logic [15:0]      data_pins_o_q,          // data driven to memory
  output logic             data_pins_oe_q,         // high while we drive data
  input  wire logic [15:0] data_pins_i             // data from memory pins
);

  // ----------------------------------------
  // state and counters
  // ----------------------------------------
  edo_ctrl_pkg::state_t state_q;              // sequencer state
  logic [3:0]           wait_q;               // cycles left in current phase
  logic [3:0]           cyc_q;                // cycles since row strobe fell
  logic [9:0]           open_row_q;           // row held open in page mode
  logic                 page_open_q;          // a row is still open
  logic [31:0]          ref_cnt_q;            // refresh interval counter
  logic                 ref_due_q;            // refresh pending
  logic [15:0]          rd_sync1_q;           // pin sampler, first stage
  logic [15:0]          rd_sync2_q;           // pin sampler, second stage
  logic                 rd_cap_q;             // capture pending in pipeline
  logic [1:0]           rd_pipe_q;            // capture delay for synchroniser

  localparam logic [3:0] ROW_CYC  = 4'(`ROW_ACCESS_CYC);
  localparam logic [3:0] PAGE_CYC = 4'(`PAGE_CYCLE_CYC);
  localparam logic [3:0] RAND_CYC = 4'(`RANDOM_CYCLE_CYC);

  wire logic same_row = page_open_q && (req_addr[19:10] == open_row_q);

  // ----------------------------------------
  // refresh pacing
  // ----------------------------------------
  // a distributed column-first refresh every gap keeps all rows fresh
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ref_cnt_q <= 32'h0;
      ref_due_q <= 1'b0;
    end else if (ref_cnt_q >= 32'(REFRESH_GAP - 1)) begin
      ref_cnt_q <= 32'h0;
      ref_due_q <= 1'b1;
    end else begin
      ref_cnt_q <= ref_cnt_q + 32'h1;
      // set wins: clearing only while in refresh
      if (state_q == edo_ctrl_pkg::ST_REF) begin
        ref_due_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // read data sampler
  // ----------------------------------------
  // pins are asynchronous to us, so two flops before use
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rd_sync1_q <= 16'h0;
      rd_sync2_q <= 16'h0;
    end else begin
      rd_sync1_q <= data_pins_i;
      rd_sync2_q <= rd_sync1_q;
    end
  end

  // ----------------------------------------
  // read response, delayed for the sampler
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rd_pipe_q   <= 2'h0;
      rsp_valid_q <= 1'b0;
      rsp_rdata_q <= 16'h0;
    end else begin
      rd_pipe_q   <= {rd_pipe_q[0], rd_cap_q};
      rsp_valid_q <= rd_pipe_q[1];
      if (rd_pipe_q[1]) begin
        rsp_rdata_q <= rd_sync2_q;
      end
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  // strobes are held long enough for the slower grade timing
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_q                  <= edo_ctrl_pkg::ST_IDLE;
      wait_q                   <= RAND_CYC;  // a cut cycle still gets its precharge
      cyc_q                    <= 4'h0;
      open_row_q               <= 10'h0;
      page_open_q              <= 1'b0;
      req_ready_q              <= 1'b0;
      rd_cap_q                 <= 1'b0;
      row_strobe_n_q           <= 1'b1;
      low_byte_col_strobe_n_q  <= 1'b1;
      high_byte_col_strobe_n_q <= 1'b1;
      write_en_n_q             <= 1'b1;
      out_en_n_q               <= 1'b1;
      mux_address_bus_q        <= 10'h0;
      data_pins_o_q            <= 16'h0;
      data_pins_oe_q           <= 1'b0;
    end else begin
      req_ready_q <= 1'b0;
      rd_cap_q    <= 1'b0;
      if (wait_q != 4'h0) begin
        wait_q <= wait_q - 4'h1;
      end
      if (cyc_q != 4'hF) begin
        cyc_q <= cyc_q + 4'h1;
      end
      case (state_q)
        edo_ctrl_pkg::ST_IDLE: begin
          // all strobes high: standby, bus released
          data_pins_oe_q <= 1'b0;
          // refresh also waits out the precharge of the cycle before
          if (ref_due_q && wait_q == 4'h0) begin
            // column strobes first, then row strobe falls next cycle
            low_byte_col_strobe_n_q  <= 1'b0;
            high_byte_col_strobe_n_q <= 1'b0;
            wait_q                   <= RAND_CYC;
            state_q                  <= edo_ctrl_pkg::ST_REF;
          end else if (req_valid && wait_q == 4'h0) begin
            row_strobe_n_q    <= 1'b0;
            mux_address_bus_q <= req_addr[19:10];
            open_row_q        <= req_addr[19:10];
            cyc_q             <= 4'h0;
            wait_q            <= 4'h2;
            state_q           <= edo_ctrl_pkg::ST_ROW;
          end
        end
        edo_ctrl_pkg::ST_ROW: begin
          // column address follows the row after hold time
          mux_address_bus_q <= req_addr[9:0];
          write_en_n_q      <= !req_write;
          out_en_n_q        <= req_write;
          data_pins_o_q     <= req_wdata;
          data_pins_oe_q    <= req_write;
          if (wait_q == 4'h1) begin
            low_byte_col_strobe_n_q  <= !req_lanes[0];
            high_byte_col_strobe_n_q <= !req_lanes[1];
            wait_q                   <= PAGE_CYC;
            state_q                  <= edo_ctrl_pkg::ST_COL;
          end
        end
        edo_ctrl_pkg::ST_COL: begin
          // hold until both page cycle and row access times have passed
          if (wait_q <= 4'h1 && cyc_q >= ROW_CYC) begin
            low_byte_col_strobe_n_q  <= 1'b1;
            high_byte_col_strobe_n_q <= 1'b1;
            req_ready_q              <= 1'b1;
            rd_cap_q                 <= !req_write;
            page_open_q              <= req_keep_page;
            wait_q                   <= 4'h1;
            state_q                  <= req_keep_page ? edo_ctrl_pkg::ST_HOLD
                                                      : edo_ctrl_pkg::ST_PRE;
          end
        end
        edo_ctrl_pkg::ST_HOLD: begin
          // page open: output stays enabled so read data is held
          write_en_n_q <= 1'b1;
          if (wait_q == 4'h0 && req_valid && same_row && !ref_due_q) begin
            mux_address_bus_q        <= req_addr[9:0];
            write_en_n_q             <= !req_write;
            out_en_n_q               <= req_write;
            data_pins_o_q            <= req_wdata;
            data_pins_oe_q           <= req_write;
            low_byte_col_strobe_n_q  <= !req_lanes[0];
            high_byte_col_strobe_n_q <= !req_lanes[1];
            wait_q                   <= PAGE_CYC;
            state_q                  <= edo_ctrl_pkg::ST_COL;
          end else if (wait_q == 4'h0 && (req_valid || ref_due_q || !req_keep_page)) begin
            row_strobe_n_q <= 1'b1;
            page_open_q    <= 1'b0;
            wait_q         <= RAND_CYC;
            state_q        <= edo_ctrl_pkg::ST_PRE;
          end
        end
        edo_ctrl_pkg::ST_PRE: begin
          // release everything; cycle ends with all strobes high
          row_strobe_n_q <= 1'b1;
          write_en_n_q   <= 1'b1;
          out_en_n_q     <= 1'b1;
          data_pins_oe_q <= 1'b0;
          page_open_q    <= 1'b0;
          state_q        <= edo_ctrl_pkg::ST_IDLE;
          wait_q         <= RAND_CYC;
        end
        edo_ctrl_pkg::ST_REF: begin
          // row strobe low with column strobes low; pins ignored
          data_pins_oe_q <= 1'b0;
          row_strobe_n_q <= (wait_q == 4'h0);
          if (wait_q == 4'h0) begin
            low_byte_col_strobe_n_q  <= 1'b1;
            high_byte_col_strobe_n_q <= 1'b1;
            wait_q                   <= RAND_CYC;
            state_q                  <= edo_ctrl_pkg::ST_IDLE;
          end
        end
        default: begin
          state_q <= edo_ctrl_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  a_refresh_col_first: assert property (
    $fell(row_strobe_n_q) && state_q == edo_ctrl_pkg::ST_REF
      |-> $past(!low_byte_col_strobe_n_q))
    else $error("row strobe fell before column strobe in refresh");
  a_refresh_bus_free: assert property (
    state_q == edo_ctrl_pkg::ST_REF |-> !data_pins_oe_q)
    else $error("data driven during refresh");
  a_page_spacing: assert property (
    $fell(low_byte_col_strobe_n_q) && row_strobe_n_q == 1'b0
      |=> low_byte_col_strobe_n_q == 1'b0)
    else $error("column strobe pulse too short");
  a_row_access_hold: assert property (
    $fell(row_strobe_n_q) && state_q != edo_ctrl_pkg::ST_REF
      |-> ##1 !req_ready_q [*3])
    else $error("access ended before row access time");
  a_read_response: assert property (
    req_ready_q && write_en_n_q |-> ##3 rsp_valid_q)
    else $error("read response missing");
  a_standby_float: assert property (
    state_q == edo_ctrl_pkg::ST_IDLE && row_strobe_n_q |=> !data_pins_oe_q)
    else $error("bus driven in standby");
  a_precharge_gap: assert property (
    $rose(row_strobe_n_q) |=> row_strobe_n_q [*2])
    else $error("row precharge too short");
  a_write_drives: assert property (
    !write_en_n_q && state_q == edo_ctrl_pkg::ST_COL |-> data_pins_oe_q)
    else $error("write without data drive");

  c_read:    cover property (rsp_valid_q);
  c_refresh: cover property (state_q == edo_ctrl_pkg::ST_REF);
  c_page:    cover property (state_q == edo_ctrl_pkg::ST_HOLD ##[1:20]
                             state_q == edo_ctrl_pkg::ST_COL);

endmodule : edo_ctrl
`default_nettype wire

// File: bench/edo_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// device model: sparse array, extended read hold
// ----------------------------------------
module edo_mem_model #(
  parameter int ACC_NS = 15  // column access delay
) (
  input  wire logic        row_strobe_n,            // row strobe
  input  wire logic        low_byte_col_strobe_n,   // lower lane strobe
  input  wire logic        high_byte_col_strobe_n,  // upper lane strobe
  input  wire logic        write_en_n,              // write enable
  input  wire logic        out_en_n,                // output enable
  input  wire logic [9:0]  mux_address_bus,         // row then column
  input  wire logic [15:0] data_in,                 // data from controller
  output logic      [15:0] data_out,                // data to controller
  output int               n_ref,                   // column-first refreshes
  output int               n_bad                    // controller timing faults
);
  logic [15:0] mem [int];  // only touched words kept
  logic [9:0]  row;        // open row
  int          addr;       // row and column
  logic [1:0]  drv;        // lanes driven
  realtime     t_row;      // last row strobe fall
  realtime     t_col;      // last column strobe fall
  realtime     t_cas;      // last column strobe fall, any kind
  // first strobe low starts, last high ends the column phase
  wire logic   cas_n = low_byte_col_strobe_n & high_byte_col_strobe_n;
  initial begin
    drv = 2'h0;
    data_out = 16'hA5A5;
    n_ref = 0;
    n_bad = 0;
    t_row = -1000.0;
    t_col = -1000.0;
    t_cas = -1000.0;
  end
  // lane writes; a missing word starts at zero
  task automatic store();
    if (!mem.exists(addr)) mem[addr] = 16'h0000;
    if (!low_byte_col_strobe_n) mem[addr][7:0] = data_in[7:0];
    if (!high_byte_col_strobe_n) mem[addr][15:8] = data_in[15:8];
  endtask : store
  // row strobe fall: open a row or count a refresh
  always @(negedge row_strobe_n) begin
    // address moves on the same edge as the strobe; let it settle
    #1;
    if ($realtime - t_row < 110.0) n_bad++;
    t_row = $realtime;
    if (!cas_n) n_ref++;
    else row = mux_address_bus;
  end
  // column fall: drop held data, then write or read
  always @(negedge cas_n) begin
    t_cas = $realtime;
    // enables, data and address may move on the strobe's own edge
    #1;
    // released lanes show the inverse, never a stale match
    if (drv != 2'h0) data_out = ~data_out;
    drv = 2'h0;
    if (!row_strobe_n) begin
      if ($realtime - t_col < 40.0) n_bad++;
      t_col = $realtime;
      addr = {row, mux_address_bus};
      if (!write_en_n) store();
      else begin
        #(ACC_NS);
        drv = {~high_byte_col_strobe_n, ~low_byte_col_strobe_n} & {2{~out_en_n}};
        if (drv[0]) data_out[7:0] = mem[addr][7:0];
        if (drv[1]) data_out[15:8] = mem[addr][15:8];
      end
    end
  end
  // late write enable: second half of read-modify-write
  always @(negedge write_en_n) begin
    #1;
    // a fall together with the column strobe is an early write, done above
    if (!row_strobe_n && !cas_n && $realtime - t_cas > 2.0) store();
  end
  // standby: all strobes high releases both lanes
  always @(posedge row_strobe_n) begin
    #1;
    if (cas_n && drv != 2'h0) begin
      data_out = ~data_out;
      drv = 2'h0;
    end
  end
endmodule : edo_mem_model
`default_nettype wire

// File: bench/test_edo_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// bench: table of accesses, then refresh and reset
// ----------------------------------------
module test_edo_ctrl;
  typedef struct packed {
    logic        wr;  // 1 write
    logic [1:0]  ln;  // lane enables
    logic [19:0] a;   // word address
    logic [15:0] d;   // written or expected data
    logic        kp;  // keep page open
  } row_t;
  localparam int GAP = 200;  // short refresh spacing
  logic        clk_sys, nrst, req_valid, req_write, req_keep_page;  // bench drives
  logic [19:0] req_addr;                                  // word address
  logic [1:0]  req_lanes;                                 // lane enables
  logic [15:0] req_wdata, rsp_rdata_q, dout, dpo, dev, rd, m;  // data paths
  logic        req_ready_q, rsp_valid_q, ras_n, lo_n, hi_n, we_n, oe_n, doe;  // outputs
  logic [9:0]  mab;                                       // address pins
  int          errors, n_tests, cyc, nref, nbad, r0;      // counters
  row_t rows [11] = '{
    '{1'b1, 2'h3, 20'h00123, 16'hA55A, 1'b0}, '{1'b0, 2'h3, 20'h00123, 16'hA55A, 1'b0},
    '{1'b1, 2'h1, 20'h00123, 16'h00FF, 1'b0}, '{1'b1, 2'h2, 20'h00123, 16'h3C00, 1'b0},
    '{1'b0, 2'h1, 20'h00123, 16'h00FF, 1'b0}, '{1'b0, 2'h2, 20'h00123, 16'h3C00, 1'b0},
    '{1'b1, 2'h3, 20'hFFFFF, 16'h1234, 1'b1}, '{1'b1, 2'h3, 20'hFFC00, 16'h8001, 1'b1},
    '{1'b0, 2'h3, 20'hFFFFF, 16'h1234, 1'b1}, '{1'b0, 2'h3, 20'hFFC00, 16'h8001, 1'b0},
    '{1'b0, 2'h3, 20'h00123, 16'h3CFF, 1'b0}};
  // pin wire: controller drive wins, else device lanes
  assign dout = doe ? dpo : dev;
  edo_ctrl #(.REFRESH_GAP(GAP)) uut (.clk_sys(clk_sys), .nrst(nrst), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_lanes(req_lanes),
    .req_wdata(req_wdata), .req_keep_page(req_keep_page), .req_ready_q(req_ready_q),
    .rsp_valid_q(rsp_valid_q), .rsp_rdata_q(rsp_rdata_q), .row_strobe_n_q(ras_n),
    .low_byte_col_strobe_n_q(lo_n), .high_byte_col_strobe_n_q(hi_n), .write_en_n_q(we_n),
    .out_en_n_q(oe_n), .mux_address_bus_q(mab), .data_pins_o_q(dpo),
    .data_pins_oe_q(doe), .data_pins_i(dout));
  edo_mem_model #(.ACC_NS(15)) mem (.row_strobe_n(ras_n), .low_byte_col_strobe_n(lo_n),
    .high_byte_col_strobe_n(hi_n), .write_en_n(we_n), .out_en_n(oe_n),
    .mux_address_bus(mab), .data_in(doe ? dpo : ~dpo), .data_out(dev),
    .n_ref(nref), .n_bad(nbad));
  // 50 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // hang guard, well above the expected run
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 6000) begin
      errors++;
      $display("[FAIL] timeout expected finish seen hang");
      summarize();
    end
  end
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  // one request held until the accept pulse; reads wait for data
  task automatic access(input row_t r, output logic [15:0] q);
    int k;
    @(negedge clk_sys);
    {req_valid, req_write, req_lanes, req_addr, req_wdata, req_keep_page} = {1'b1, r};
    for (k = 0; k < 300 && req_ready_q !== 1'b1; k++) begin
      @(posedge clk_sys);
      #1;
    end
    check("accept", 16'h0001, {15'h0, req_ready_q});
    @(negedge clk_sys);
    req_valid = 1'b0;
    for (k = 0; k < 10 && !r.wr && rsp_valid_q !== 1'b1; k++) begin
      @(posedge clk_sys);
      #1;
    end
    if (!r.wr) check("read valid", 16'h0001, {15'h0, rsp_valid_q});
    q = rsp_rdata_q;
  endtask : access
  initial begin
    {nrst, req_valid, req_write, req_keep_page, req_addr, req_lanes, req_wdata} = '0;
    {errors, n_tests, cyc} = '0;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    nrst = 1'b1;
    foreach (rows[i]) begin
      access(rows[i], rd);
      m = {{8{rows[i].ln[1]}}, {8{rows[i].ln[0]}}};
      if (!rows[i].wr) check("read data", rows[i].d & m, rd & m);
    end
    $display("test access table done");
    r0 = nref;
    repeat (5 * GAP) @(posedge clk_sys);
    #1;
    check("refresh cadence", 16'h0001, {15'h0, (nref - r0 >= 4) && (nref - r0 <= 6)});
    check("timing faults", 16'h0000, nbad[15:0]);
    $display("test refresh done");
    @(negedge clk_sys);
    nrst = 1'b0;
    @(posedge clk_sys);
    #1;
    check("reset outputs", 16'h007C, {9'h0, ras_n, lo_n, hi_n, we_n, oe_n, doe, req_ready_q});
    @(negedge clk_sys);
    nrst = 1'b1;
    access(rows[10], rd);
    check("read after reset", 16'h3CFF, rd);
    $display("test reset done");
    summarize();
  end
endmodule : test_edo_ctrl
`default_nettype wire
